// ### adc_power_and_input_control_tb_top.sv
// testbench for the converter power and input control
`include "apic_consts.svh"
`default_nettype none
module adc_power_and_input_control_tb_top
    import apic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0, arst_n_i = 1'b0, go = 1'b0;
    logic        reg_wr_i = 1'b0, reg_rd_i = 1'b0, strobe_n, host_busy;
    logic [7:0]  reg_addr_i = 8'h00, low_len = 8'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
    logic [9:0]  sar_code = 10'h000, result_o;
    logic [2:0]  input_route_o;
    logic        ext_sel, acquire_o, converting_o, int_rst;
    apic_pwr_t   power_state_o;
    int          fails = 0, tests_run = 0, rst_seen = 0, n;
    localparam logic [7:0] CTRL_TAB [6] = '{8'h39, 8'h11, 8'h11,
                                            8'h21, 8'h20, 8'h10};
    localparam logic [7:0] LEN_TAB [6] = '{8'h03, 8'h03, 8'h3C,
                                           8'h03, 8'h3C, 8'h3C};
    localparam int HI_TAB [6] = '{7, 7, 7, 7, 12, 12};
    localparam apic_pwr_t PWR_TAB [6] = '{APIC_PWR_UP, APIC_PWR_UP,
        APIC_PWR_PARTIAL, APIC_PWR_UP, APIC_PWR_FULLDN, APIC_PWR_PARTIAL};
    always #25 clk_i = ~clk_i;
    always @(posedge clk_i) if (int_rst === 1'b1) rst_seen++;
    apic_ctrl #(.PUP_SHORT_CYC(4), .REF_CYC(6), .PUP_LONG_CYC(8)) i_dut (
        .clk_i, .arst_n_i, .clk_en_i(1'b1), .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .conversion_strobe_n_i(strobe_n),
        .sar_code_i(sar_code), .core_power_o(), .reference_power_o(),
        .reference_amp_power_o(), .external_reference_select_o(ext_sel),
        .reference_hold_switch_o(), .acquire_o, .converting_o,
        .input_route_o, .cap_to_second_input_o(), .cap_to_analog_ground_o(),
        .internal_reset_o(int_rst), .power_state_o, .result_o,
        .result_valid_o());
    apic_host_mdl i_host (.clk_i, .start_i(go), .low_len_i(low_len),
        .conversion_strobe_n_o(strobe_n), .busy_o(host_busy));
    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp);
        @(posedge clk_i);
    endtask
    // counts cycles until the part is acquiring again
    task automatic wait_acq(input int lo, input int hi);
        n = 0;
        #1;
        while (acquire_o !== 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1 n++;
        end
        chk({31'h0000_0000, n >= lo && n <= hi}, 32'h0000_0001);
        @(posedge clk_i);
    endtask
    task automatic conv(input logic [7:0] len, input logic [9:0] code,
                        input apic_pwr_t pwr);
        sar_code <= code;
        low_len <= len;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (51) @(posedge clk_i);
        #1 chk(result_o, code);
        chk(power_state_o, pwr);
        while (host_busy === 1'b1) begin
            @(posedge clk_i);
            #1;
        end
        @(posedge clk_i);
    endtask
    task automatic stop_test();
        $display("checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (5000) @(posedge clk_i);
        fails++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        arst_n_i <= 1'b1;
        @(posedge clk_i);
        rd(`APIC_REG_STATUS, 32'h0000_0002);
        rd(8'h10, 32'h0000_0000);
        go <= 1'b1;
        low_len <= 8'h03;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (3) @(posedge clk_i);
        #1 chk(converting_o, 1'b0);
        @(posedge clk_i);
        wr(`APIC_REG_CTRL, 32'h0000_0030);
        wait_acq(7, 12);
        wr(`APIC_REG_CTRL, 32'h0000_0000);
        wr(`APIC_REG_CTRL, 32'h0000_0030);
        repeat (2) @(posedge clk_i);
        chk(rst_seen, 1);
        wr(`APIC_REG_CTRL, 32'h0000_0031);
        wait_acq(2, 7);
        for (int i = 0; i < 6; i++) begin
            wr(`APIC_REG_CTRL, {24'h00_0000, CTRL_TAB[i]});
            #1 chk(input_route_o, CTRL_TAB[i][3:1]);
            chk(ext_sel, CTRL_TAB[i][0]);
            repeat (2) @(posedge clk_i);
            conv(LEN_TAB[i], 10'h2A5 ^ 10'(i), PWR_TAB[i]);
            if (PWR_TAB[i] != APIC_PWR_UP) wait_acq(2, HI_TAB[i]);
        end
        rd(`APIC_REG_RESULT, 32'h0000_02A0);
        // strobe falls while the part is acquiring after the partial pd wake; the next one falls while it is still waking
        conv(8'h3C, 10'h0F0, APIC_PWR_PARTIAL);
        conv(8'h03, 10'h155, APIC_PWR_UP);
        wr(`APIC_REG_CTRL, 32'h0000_0000);
        #1 chk(power_state_o, APIC_PWR_FULLDN);
        stop_test();
    end
endmodule
`default_nettype wire

// ### apic_consts.svh
// timing counts, field positions and reset values for the converter control
`ifndef APIC_CONSTS_SVH
`define APIC_CONSTS_SVH

`define APIC_CLK_MHZ         20
`define APIC_T_PUP_SHORT_NS  1500
`define APIC_T_REF_US        30
`define APIC_T_PUP_LONG_US   182
`define APIC_T_CONV_NS       2300
`define APIC_T_ACQ_NS        100
// longest times round down, least times round up, never below one cycle
`define APIC_CYC_PUP_SHORT   ((`APIC_T_PUP_SHORT_NS * `APIC_CLK_MHZ) / 1000)
`define APIC_CYC_REF         (`APIC_T_REF_US * `APIC_CLK_MHZ)
`define APIC_CYC_PUP_LONG    (`APIC_T_PUP_LONG_US * `APIC_CLK_MHZ)
`define APIC_CYC_CONV        ((`APIC_T_CONV_NS * `APIC_CLK_MHZ) / 1000)
`define APIC_CYC_ACQ         ((`APIC_T_ACQ_NS * `APIC_CLK_MHZ + 999) / 1000)

`define APIC_REG_CTRL        8'h00
`define APIC_REG_STATUS      8'h04
`define APIC_REG_RESULT      8'h08
`define APIC_REG_LONGPD      8'h0C

`define APIC_CTRL_EXTERNAL_REFERENCE_SELECT     0
`define APIC_CTRL_CHA        1
`define APIC_CTRL_CHB        2
`define APIC_CTRL_PAIR       3
`define APIC_CTRL_PD0        4
`define APIC_CTRL_PD1        5
`define APIC_CTRL_RESET      8'h00
`define APIC_LONGPD_RESET    24'h00_4E20

`endif

// ### apic_ctrl.sv
// power-down decode, wake-up timing, acquisition and input routing
//
// Our own choices: the register addresses and strobed register access.
`include "apic_consts.svh"
`default_nettype none

// What this block does
// - power bits plus strobe level at conversion end pick power state
// - rising strobe edge wakes device from automatic power-down
// - partial power-down keeps reference on; full power-down turns it off
// - power bits written 00 then 11 raise one internal reset
// - start powered down; host writes 11 before any conversion
// - wake within 1.5 us for external ref full pd, charged partial or short full
// - first or long full power-down with internal ref waits 182 us
// - partial power-down mode is ready 30 us after first supply
// - acquisition runs from conversion end to strobe fall; host allows 100 ns
// - control bit zero selects external reference, internal amp off
// - results are straight binary codes, step is reference over 1024
// - pair mode, channel zero: sample first input, second as reference
// - single-ended conversion ties sampling capacitor to analog ground
// - automatic power-down with internal ref opens reference hold switch
// - conversion ends 2.3 us after strobe fall; latch result, decide power
// - strobe fall during power-up waits until power-up has finished
module apic_ctrl
    import apic_pkg::*;
#(
    parameter int PUP_SHORT_CYC = `APIC_CYC_PUP_SHORT,
    parameter int REF_CYC       = `APIC_CYC_REF,
    parameter int PUP_LONG_CYC  = `APIC_CYC_PUP_LONG,
    parameter int CONV_CYC      = `APIC_CYC_CONV,
    parameter int RES_W         = 10
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             clk_en_i,
    // register port
    input  wire logic [7:0]       reg_addr_i,
    input  wire logic [31:0]      reg_wdata_i,
    input  wire logic             reg_wr_i,
    input  wire logic             reg_rd_i,
    output logic      [31:0]      reg_rdata_o,
    // host strobe and converter core
    input  wire logic             conversion_strobe_n_i,
    input  wire logic [RES_W-1:0] sar_code_i,
    // analog switch and power controls
    output logic                  core_power_o,
    output logic                  reference_power_o,
    output logic                  reference_amp_power_o,
    output logic                  external_reference_select_o,
    output logic                  reference_hold_switch_o,
    output logic                  acquire_o,
    output logic                  converting_o,
    output logic [2:0]            input_route_o,
    output logic                  cap_to_second_input_o,
    output logic                  cap_to_analog_ground_o,
    output logic                  internal_reset_o,
    output apic_pwr_t             power_state_o,
    output logic [RES_W-1:0]      result_o,
    output logic                  result_valid_o
);

    // ------------------------------------------------------------------
    // registers and decode
    // ------------------------------------------------------------------
    logic [7:0]        ctrl_r;
    logic [23:0]       longpd_r;
    logic [31:0]       rdata_r;
    apic_state_t       state_r;
    apic_pwr_t         pwr_r;
    logic [23:0]       cnt_r;
    logic [23:0]       idle_cnt_r;
    logic              strobe_d_r;
    logic              start_pend_r;
    logic              cap_charged_r;
    logic              was_zero_r;
    logic              rst_pulse_r;
    logic [RES_W-1:0]  result_r;
    logic              valid_r;

    wire wr_ctrl   = reg_wr_i && reg_addr_i == `APIC_REG_CTRL;
    wire wr_longpd = reg_wr_i && reg_addr_i == `APIC_REG_LONGPD;
    wire [1:0] pd_bits = {ctrl_r[`APIC_CTRL_PD1], ctrl_r[`APIC_CTRL_PD0]};
    wire [1:0] pd_wr   = {reg_wdata_i[`APIC_CTRL_PD1],
                          reg_wdata_i[`APIC_CTRL_PD0]};
    wire ext_ref   = ctrl_r[`APIC_CTRL_EXTERNAL_REFERENCE_SELECT];
    wire pair_mode = ctrl_r[`APIC_CTRL_PAIR];
    wire strobe_rise = conversion_strobe_n_i && !strobe_d_r;
    wire strobe_fall = !conversion_strobe_n_i && strobe_d_r;
    wire auto_pd   = pd_bits == 2'b01 || pd_bits == 2'b10;
    wire conv_done = state_r == APIC_CONVERT &&
                     cnt_r == 24'(CONV_CYC - 1);
    wire wake_done = state_r == APIC_WAKE && cnt_r == 24'd0;

    // ------------------------------------------------------------------
    // power decision at end of conversion
    // ------------------------------------------------------------------
    apic_pwr_t eoc_pwr;
    always_comb begin
        unique case (pd_bits)
            2'b11: eoc_pwr = APIC_PWR_UP;
            2'b00: eoc_pwr = APIC_PWR_FULLDN;
            2'b01: eoc_pwr = conversion_strobe_n_i ? APIC_PWR_UP
                                                    : APIC_PWR_PARTIAL;
            2'b10: eoc_pwr = conversion_strobe_n_i ? APIC_PWR_UP
                                                    : APIC_PWR_FULLDN;
        endcase
    end

    // wake length: short unless the internal reference must recharge
    // a wake by write must judge the reference chosen in that same write
    wire ext_ref_nxt = wr_ctrl ? reg_wdata_i[`APIC_CTRL_EXTERNAL_REFERENCE_SELECT] : ext_ref;
    wire long_wake = !ext_ref_nxt && pwr_r == APIC_PWR_FULLDN &&
                     (!cap_charged_r || idle_cnt_r >= longpd_r);
    wire [23:0] wake_len =
        pwr_r == APIC_PWR_PARTIAL && !cap_charged_r ? 24'(REF_CYC)
      : long_wake ? 24'(PUP_LONG_CYC)
      : 24'(PUP_SHORT_CYC);

    // a wake request comes from a strobe rise in auto mode or a 11 write
    wire wake_strobe = auto_pd && strobe_rise;
    wire wake_write  = wr_ctrl && pd_wr == 2'b11;
    wire seq_reset   = wake_write && was_zero_r;

    // ------------------------------------------------------------------
    // register writes and readback
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctrl_r     <= `APIC_CTRL_RESET;
            longpd_r   <= `APIC_LONGPD_RESET;
            was_zero_r <= 1'b0;
        end else if (clk_en_i) begin
            if (wr_ctrl) begin
                ctrl_r     <= reg_wdata_i[7:0];
                was_zero_r <= pd_wr == 2'b00;
            end
            if (wr_longpd) begin
                longpd_r <= reg_wdata_i[23:0];
            end
        end
    end

    wire [31:0] rd_mux =
        reg_addr_i == `APIC_REG_CTRL   ? {24'h00_0000, ctrl_r}
      : reg_addr_i == `APIC_REG_STATUS ? {25'h000_0000, valid_r,
                                          state_r, 1'b0, pwr_r}
      : reg_addr_i == `APIC_REG_RESULT ? {22'h00_0000, result_r}
      : reg_addr_i == `APIC_REG_LONGPD ? {8'h00, longpd_r}
      : 32'h0000_0000;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (clk_en_i) begin
            rdata_r <= reg_rd_i ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // power sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state_r       <= APIC_OFF;
            pwr_r         <= APIC_PWR_FULLDN;
            cnt_r         <= 24'd0;
            idle_cnt_r    <= 24'd0;
            strobe_d_r    <= 1'b1;
            start_pend_r  <= 1'b0;
            cap_charged_r <= 1'b0;
            rst_pulse_r   <= 1'b0;
            result_r      <= '0;
            valid_r       <= 1'b0;
        end else if (clk_en_i) begin
            strobe_d_r  <= conversion_strobe_n_i;
            rst_pulse_r <= seq_reset;
            if (state_r == APIC_OFF && idle_cnt_r != 24'hFF_FFFF) begin
                idle_cnt_r <= idle_cnt_r + 24'd1;
            end
            if (seq_reset) begin
                state_r      <= APIC_RST;
                start_pend_r <= 1'b0;
                valid_r      <= 1'b0;
            end else if (wr_ctrl && pd_wr == 2'b00) begin
                state_r      <= APIC_OFF;
                pwr_r        <= APIC_PWR_FULLDN;
                idle_cnt_r   <= 24'd0;
                start_pend_r <= 1'b0;
            end else begin
                unique case (state_r)
                    APIC_RST: begin
                        state_r <= APIC_OFF;
                    end
                    APIC_OFF: begin
                        if (wake_write || wake_strobe) begin
                            state_r      <= APIC_WAKE;
                            cnt_r        <= wake_len - 24'd1;
                            start_pend_r <= 1'b0;
                        end
                    end
                    APIC_WAKE: begin
                        if (strobe_fall) begin
                            start_pend_r <= 1'b1;
                        end
                        if (wake_done) begin
                            pwr_r         <= APIC_PWR_UP;
                            cap_charged_r <= !ext_ref;
                            cnt_r         <= 24'd0;
                            state_r       <= (start_pend_r || strobe_fall)
                                             ? APIC_CONVERT : APIC_IDLE;
                        end else begin
                            cnt_r <= cnt_r - 24'd1;
                        end
                    end
                    APIC_IDLE: begin
                        if (strobe_fall) begin
                            state_r <= APIC_CONVERT;
                            cnt_r   <= 24'd0;
                        end
                    end
                    APIC_CONVERT: begin
                        if (conv_done) begin
                            result_r <= sar_code_i;
                            valid_r  <= 1'b1;
                            pwr_r    <= eoc_pwr;
                            state_r  <= eoc_pwr == APIC_PWR_UP
                                        ? APIC_IDLE : APIC_OFF;
                            idle_cnt_r <= 24'd0;
                        end else begin
                            cnt_r <= cnt_r + 24'd1;
                        end
                    end
                    default: state_r <= APIC_OFF;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // analog controls
    // ------------------------------------------------------------------
    wire powered = state_r == APIC_IDLE || state_r == APIC_CONVERT;
    wire [2:0] chan = {pair_mode, ctrl_r[`APIC_CTRL_CHB],
                       ctrl_r[`APIC_CTRL_CHA]};

    assign core_power_o           = powered || state_r == APIC_WAKE;
    assign reference_power_o      = !ext_ref &&
                                    (core_power_o ||
                                     pwr_r == APIC_PWR_PARTIAL);
    assign reference_amp_power_o  = reference_power_o;
    assign external_reference_select_o = ext_ref;
    // opening the hold switch lets the reference capacitor keep its charge
    assign reference_hold_switch_o = !ext_ref && core_power_o;
    assign acquire_o              = state_r == APIC_IDLE;
    assign converting_o           = state_r == APIC_CONVERT;
    assign input_route_o          = chan;
    assign cap_to_second_input_o  = converting_o && pair_mode &&
                                    chan[1:0] == 2'b00;
    assign cap_to_analog_ground_o = converting_o && !pair_mode;
    assign internal_reset_o       = rst_pulse_r;
    assign power_state_o          = pwr_r;
    assign result_o               = result_r;
    assign result_valid_o         = valid_r;
    assign reg_rdata_o            = rdata_r;

endmodule
`default_nettype wire

// ### apic_ctrl_props.sv
// port assertions for the converter power and input control
`default_nettype none
module apic_ctrl_props
    import apic_pkg::*;
#(
    parameter int CONV_CYC = 46
) (
    // clock and reset
    input wire logic       clk_i,
    input wire logic       arst_n_i,
    // watched signals
    input wire logic       conversion_strobe_n_i,
    input wire logic       core_power_o,
    input wire logic       reference_power_o,
    input wire logic       reference_amp_power_o,
    input wire logic       external_reference_select_o,
    input wire logic       reference_hold_switch_o,
    input wire logic       acquire_o,
    input wire logic       converting_o,
    input wire logic [2:0] input_route_o,
    input wire logic       cap_to_second_input_o,
    input wire logic       cap_to_analog_ground_o,
    input wire logic       internal_reset_o,
    input var  apic_pwr_t  power_state_o
);
    logic [7:0] conv_cnt_r;
    // length of the running conversion, in cycles
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_cnt_r <= 8'h00;
        end else begin
            conv_cnt_r <= converting_o ? conv_cnt_r + 8'h01 : 8'h00;
        end
    end
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    a_conv_length: assert property (
        $fell(converting_o) |-> conv_cnt_r == 8'(CONV_CYC))
        else $error("conversion length wrong");
    a_fall_starts: assert property (
        acquire_o && $fell(conversion_strobe_n_i) |-> ##[1:2] converting_o)
        else $error("strobe fall did not start conversion");
    a_off_no_conv: assert property (
        !core_power_o && power_state_o == APIC_PWR_FULLDN |=> !converting_o)
        else $error("conversion while powered down");
    a_ext_ref_off: assert property (
        external_reference_select_o |-> !reference_amp_power_o)
        else $error("internal amplifier on with external reference");
    a_pair_second: assert property (
        converting_o && input_route_o == 3'b100
        |-> cap_to_second_input_o && !cap_to_analog_ground_o)
        else $error("pair mode capacitor not on second input");
    a_sgl_ground: assert property (
        converting_o && !input_route_o[2] |-> cap_to_analog_ground_o)
        else $error("single-ended capacitor not on ground");
    a_partial_ref: assert property (
        !core_power_o && power_state_o == APIC_PWR_PARTIAL
        && !external_reference_select_o |-> reference_power_o)
        else $error("reference off in partial power-down");
    a_full_ref_off: assert property (
        !core_power_o && power_state_o == APIC_PWR_FULLDN
        |-> !reference_power_o)
        else $error("reference on in full power-down");
    a_hold_open: assert property (
        !core_power_o |-> !reference_hold_switch_o)
        else $error("hold switch closed while powered down");
    a_reset_pulse: assert property (
        internal_reset_o |=> !internal_reset_o)
        else $error("internal reset longer than one cycle");
endmodule

bind apic_ctrl apic_ctrl_props #(.CONV_CYC(CONV_CYC)) i_props (
    .clk_i(clk_i), .arst_n_i(arst_n_i),
    .conversion_strobe_n_i(conversion_strobe_n_i),
    .core_power_o(core_power_o), .reference_power_o(reference_power_o),
    .reference_amp_power_o(reference_amp_power_o),
    .external_reference_select_o(external_reference_select_o),
    .reference_hold_switch_o(reference_hold_switch_o),
    .acquire_o(acquire_o), .converting_o(converting_o),
    .input_route_o(input_route_o),
    .cap_to_second_input_o(cap_to_second_input_o),
    .cap_to_analog_ground_o(cap_to_analog_ground_o),
    .internal_reset_o(internal_reset_o), .power_state_o(power_state_o));
`default_nettype wire

// ### apic_host_mdl.sv
// host model that drives the active-low conversion strobe
`default_nettype none
module apic_host_mdl (
    // clock
    input  wire logic       clk_i,
    // commands from the bench
    input  wire logic       start_i,
    input  wire logic [7:0] low_len_i,
    // strobe towards the device
    output logic            conversion_strobe_n_o,
    output logic            busy_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_r = 8'h00;
    initial conversion_strobe_n_o = 1'b1;
    initial busy_o = 1'b0;
    // a long low pulse asks for power-down; its rising edge wakes the part
    always @(posedge clk_i) begin
        if (start_i) begin
            conversion_strobe_n_o <= 1'b0;
            busy_o <= 1'b1;
            cnt_r <= low_len_i;
        end else if (cnt_r > 8'h01) begin
            cnt_r <= cnt_r - 8'h01;
        end else if (busy_o) begin
            conversion_strobe_n_o <= 1'b1;
            busy_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### apic_pkg.sv
// types shared by the converter power and input control
`default_nettype none
package apic_pkg;
    typedef enum logic [2:0] {
        APIC_OFF     = 3'b000,
        APIC_WAKE    = 3'b001,
        APIC_IDLE    = 3'b011,
        APIC_CONVERT = 3'b010,
        APIC_RST     = 3'b110
    } apic_state_t;

    typedef enum logic [1:0] {
        APIC_PWR_UP      = 2'b00,
        APIC_PWR_PARTIAL = 2'b01,
        APIC_PWR_FULLDN  = 2'b10
    } apic_pwr_t;
endpackage
`default_nettype wire
